// File: flash_wp_consts.svh
// Constants for the status-write and write-protection link
//
// Overview of operation
// R1 - One-time bottom-protect bit, default top area
// R2 - Bottom-protect bit changes only by status write
// R3 - Config: dummy select bit7, bottom bit3
// R4 - Dummy select gives 8 clocks, else 6
// R5 - Status write needs write latch set first
// R6 - Status write data never alters latch or busy
// R7 - Status write refused in hard protect mode
// R8 - Host: select low, opcode 01, data, release
// R9 - Select released off byte boundary rejects write
// R10 - Timed write cycle starts at select release
// R11 - Busy during cycle; end clears busy, latch
// R12 - Lock bit 0 means soft protect mode
// R13 - Lock 1, pin high stays soft protect
// R14 - Lock 1, pin low enters hard protect
// R15 - Both modes block program/erase on protected area
// R16 - Only pin high leaves hard protect mode
// R17 - Quad enable disables hard protect mode
// R18 - Status layout: lock,quad,level[3:0],latch,busy
// R19 - Write enable sets latch; others clear it
// R20 - Protected program/erase ignored, latch cleared
// R21 - Non-volatile bits survive reset; timed cycle count
// R22 - Bottom-protect bit never returns to zero
`ifndef FLASH_WP_CONSTS_SVH
`define FLASH_WP_CONSTS_SVH
// Opcodes
`define CMD_WRITE_ENABLE  8'h06
`define CMD_WRITE_DISABLE 8'h04
`define CMD_READ_STATUS   8'h05
`define CMD_WRITE_STATUS  8'h01
`define CMD_READ_CONFIG   8'h15
// Configuration bit positions
`define CFG_DUMMY_BIT     7
`define CFG_BOTTOM_BIT    3
// Dummy clock counts
`define DUMMY_CLKS_HIGH   4'h8
`define DUMMY_CLKS_LOW    4'h6
// Timing
`define SYS_CLK_NS        10
`define STATUS_WRITE_NS   40000
`define STATUS_WRITE_CYC  (`STATUS_WRITE_NS / `SYS_CLK_NS)
`define HOST_HALF_DIV     10
// Host register byte offsets
`define REG_CMD           8'h00
`define REG_TXDATA        8'h04
`define REG_RXDATA        8'h08
`define REG_STATUS        8'h0c
`define REG_WPCTRL        8'h10
// Host command register fields
`define CMD_LEN_LSB       8
`define CMD_TRUNC_BIT     12
// Idle pin levels: select high, clock low, data low, protect high
`define PIN_IDLE          4'h9
`endif

// File: flash_wp_pkg.sv
// Types shared by both ends of the status-write link
`default_nettype none
package flash_wp_pkg;
   // Status register layout, bit7 first
   typedef struct packed {
      logic       lockBit;
      logic       quadEn;
      logic [3:0] level;
      logic       latch;
      logic       busy;
   } status_t;
   typedef enum {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_HOLD, H_GAP} host_state_t;
endpackage
`default_nettype wire

// File: flash_wp_link_if.sv
// Serial link between host controller and flash protection logic
`default_nettype none
interface flash_wp_link_if;
   logic chipSelectN;
   logic serialClk;
   logic serialIn;
   logic serialOut;
   logic writeProtectPin;
   modport device (input chipSelectN, serialClk, serialIn, writeProtectPin,
                   output serialOut);
   modport host (output chipSelectN, serialClk, serialIn, writeProtectPin,
                 input serialOut);
endinterface
`default_nettype wire

// File: flash_wp_device.sv
// Flash status/config write path and write-protection logic
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`include "flash_wp_consts.svh"
`default_nettype none
module flash_wp_device #(
   parameter int unsigned STATUS_WRITE_CYCLES = `STATUS_WRITE_CYC
) (
   // Clock and resets
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             powerOnRst,
   // Serial link
   flash_wp_link_if.device       link,
   // Array program/erase requests
   input  wire logic             arrayOpReq,
   input  wire logic [3:0]       arrayOpBlock,
   output logic                  arrayOpGranted,
   output logic                  arrayOpRefused,
   // Protection state
   output flash_wp_pkg::status_t statusOut,
   output logic [7:0]            configOut,
   output logic                  hardProtect,
   output logic [3:0]            dummyClocks
);
   import flash_wp_pkg::*;

   // Pin vector order: select, clock, data, protect
   logic [3:0]  sync1_r;
   logic [3:0]  sync2_r;
   logic [3:0]  sync3_r;
   logic [3:0]  pin_r;
   logic [3:0]  pinPrev_r;
   logic        csN;
   logic        csFall;
   logic        csRise;
   logic        sclkRise;
   logic        sclkFall;
   logic        wpHigh;
   // Non-volatile bits
   logic        lockBit_r;
   logic        quadEn_r;
   logic [3:0]  level_r;
   logic        fromBottom_r;
   // Volatile bits
   logic        latch_r;
   logic        busy_r;
   logic        dummySel_r;
   logic [31:0] busyCnt_r;
   // Frame capture
   logic [5:0]  bitCnt_r;
   logic [23:0] rx_r;
   logic [7:0]  cmd_r;
   logic        serialOut_r;
   // Decoded frame end events
   logic        frameOk;
   logic        wrenEv;
   logic        wrdiEv;
   logic        wrsrEv;
   logic [7:0]  newStatus;
   logic [7:0]  newConfig;
   logic        hasConfig;
   logic        blockProt;

   // True if a block lies in the area set by level and side
   function automatic logic isProtected(input logic [3:0] blk,
                                        input logic [3:0] lvl,
                                        input logic       bottom);
      logic [4:0] lim;
      lim = 5'h10 - {1'b0, lvl};
      if (lvl == 4'h0)
         isProtected = 1'b0;
      else if (bottom)
         isProtected = {1'b0, blk} < {1'b0, lvl};
      else
         isProtected = {1'b0, blk} >= lim;
   endfunction

   // Three-stage sampling; a level counts once stages 2 and 3 agree
   always_ff @(posedge sys_clk) begin
      if (rst | powerOnRst) begin
         // Start at idle levels so reset shows no false edge or lock
         sync1_r   <= `PIN_IDLE;
         sync2_r   <= `PIN_IDLE;
         sync3_r   <= `PIN_IDLE;
         pin_r     <= `PIN_IDLE;
         pinPrev_r <= `PIN_IDLE;
      end else begin
         sync1_r   <= {link.writeProtectPin, link.serialIn,
                       link.serialClk, link.chipSelectN};
         sync2_r   <= sync1_r;
         sync3_r   <= sync2_r;
         pin_r     <= (sync2_r & sync3_r) | (pin_r & (sync2_r | sync3_r));
         pinPrev_r <= pin_r;
      end
   end

   assign csN      = pin_r[0];
   assign csFall   = pinPrev_r[0] & ~pin_r[0];
   assign csRise   = ~pinPrev_r[0] & pin_r[0];
   assign sclkRise = ~csN & ~pinPrev_r[1] & pin_r[1];
   assign sclkFall = ~csN & pinPrev_r[1] & ~pin_r[1];
   assign wpHigh   = pin_r[3];

   // Hard mode needs lock set and pin low; quad use of pin disables it
   assign hardProtect = lockBit_r & ~wpHigh & ~quadEn_r; // see R14 R16 R17

   // Shift in on rising clock edges while selected
   always_ff @(posedge sys_clk) begin
      if (rst | powerOnRst) begin
         bitCnt_r <= 6'h00;
         rx_r     <= 24'h000000;
         cmd_r    <= 8'h00;
      end else if (csFall) begin
         bitCnt_r <= 6'h00;
         cmd_r    <= 8'h00;
      end else if (sclkRise) begin
         rx_r <= {rx_r[22:0], pin_r[2]};
         if (bitCnt_r != 6'h3f)
            bitCnt_r <= bitCnt_r + 6'h01;
         if (bitCnt_r == 6'h07)
            cmd_r <= {rx_r[6:0], pin_r[2]};
      end
   end

   // Decode at select release; only whole bytes count
   always_comb begin
      frameOk   = csRise & (bitCnt_r[2:0] == 3'h0); // see R9
      hasConfig = (bitCnt_r == 6'h18);
      newStatus = hasConfig ? rx_r[15:8] : rx_r[7:0];
      newConfig = rx_r[7:0];
      wrenEv = frameOk & (bitCnt_r == 6'h08) & ~busy_r &
               (rx_r[7:0] == `CMD_WRITE_ENABLE);
      wrdiEv = frameOk & (bitCnt_r == 6'h08) & ~busy_r &
               (rx_r[7:0] == `CMD_WRITE_DISABLE);
      // Needs latch, idle device and no hard protect
      wrsrEv = frameOk & ((bitCnt_r == 6'h10) | hasConfig) &
               ((hasConfig ? rx_r[23:16] : rx_r[15:8]) ==
                `CMD_WRITE_STATUS) &
               latch_r & ~busy_r & ~hardProtect; // see R5 R7 R8
   end

   // Non-volatile bits: only a power-on clear, device reset keeps them
   always_ff @(posedge sys_clk) begin
      if (powerOnRst) begin // see R21
         lockBit_r    <= 1'b0;
         quadEn_r     <= 1'b0;
         level_r      <= 4'h0;
         fromBottom_r <= 1'b0; // see R1
      end else if (wrsrEv) begin
         // Latch and busy positions of the data are dropped
         lockBit_r <= newStatus[7]; // see R6 R12 R13
         quadEn_r  <= newStatus[6];
         level_r   <= newStatus[5:2]; // see R18
         // One-time bit can only be set, never cleared
         if (hasConfig)
            fromBottom_r <= fromBottom_r |
                            newConfig[`CFG_BOTTOM_BIT]; // see R2 R22
      end
   end

   // Volatile dummy select, cleared on any reset
   always_ff @(posedge sys_clk) begin
      if (rst | powerOnRst)
         dummySel_r <= 1'b0;
      else if (wrsrEv & hasConfig)
         dummySel_r <= newConfig[`CFG_DUMMY_BIT]; // see R3
   end

   // Self-timed write cycle from select release
   always_ff @(posedge sys_clk) begin
      if (rst | powerOnRst) begin
         busy_r    <= 1'b0;
         busyCnt_r <= 32'h0;
      end else if (wrsrEv) begin
         busy_r    <= 1'b1; // see R10
         busyCnt_r <= STATUS_WRITE_CYCLES - 32'h1; // see R21
      end else if (busy_r) begin
         if (busyCnt_r == 32'h0)
            busy_r <= 1'b0; // see R11
         else
            busyCnt_r <= busyCnt_r - 32'h1;
      end
   end

   // Array request hits a protected block in either mode
   assign blockProt = isProtected(arrayOpBlock, level_r, fromBottom_r);

   // Grant or refusal of an array operation, one-cycle pulses
   always_ff @(posedge sys_clk) begin
      if (rst | powerOnRst) begin
         arrayOpGranted <= 1'b0;
         arrayOpRefused <= 1'b0;
      end else begin
         arrayOpGranted <= arrayOpReq & latch_r & ~busy_r & ~blockProt;
         arrayOpRefused <= arrayOpReq & ~busy_r &
                           (blockProt | ~latch_r); // see R15 R20
      end
   end

   // Write latch: set wins over a clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (rst | powerOnRst)
         latch_r <= 1'b0; // see R19
      else if (wrenEv)
         latch_r <= 1'b1; // see R19
      else if (wrdiEv | (arrayOpReq & ~busy_r & latch_r) |
               (busy_r & busyCnt_r == 32'h0))
         latch_r <= 1'b0; // see R11 R19 R20
   end

   // Readback: status polled live even while busy
   always_ff @(posedge sys_clk) begin
      if (rst | powerOnRst)
         serialOut_r <= 1'b0;
      else if (csN)
         serialOut_r <= 1'b0;
      else if (sclkFall & (bitCnt_r >= 6'h08)) begin
         if (cmd_r == `CMD_READ_STATUS)
            serialOut_r <= statusOut[~bitCnt_r[2:0]]; // see R11
         else if (cmd_r == `CMD_READ_CONFIG)
            serialOut_r <= configOut[~bitCnt_r[2:0]];
         else
            serialOut_r <= 1'b0;
      end
   end

   assign link.serialOut = serialOut_r;

   // Register images and dummy count
   always_comb begin
      statusOut.lockBit = lockBit_r;
      statusOut.quadEn  = quadEn_r;
      statusOut.level   = level_r;
      statusOut.latch   = latch_r;
      statusOut.busy    = busy_r;
      configOut         = 8'h00;
      configOut[`CFG_DUMMY_BIT]  = dummySel_r;
      configOut[`CFG_BOTTOM_BIT] = fromBottom_r;
      dummyClocks = dummySel_r ? `DUMMY_CLKS_HIGH
                               : `DUMMY_CLKS_LOW; // see R4
   end
endmodule // flash_wp_device
`default_nettype wire

// File: flash_wp_host.sv
// Host serial controller with AHB-Lite command registers
`include "flash_wp_consts.svh"
`default_nettype none
module flash_wp_host #(
   parameter int unsigned HALF_DIV = `HOST_HALF_DIV
) (
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Serial link
   flash_wp_link_if.host    link
);
   import flash_wp_pkg::*;

   host_state_t state_r;
   logic [7:0]  wrAddr_r;
   logic        wrPend_r;
   logic [23:0] txData_r;
   logic [23:0] rxData_r;
   logic        wpLevel_r;
   logic [31:0] shift_r;
   logic [5:0]  total_r;
   logic [5:0]  done_r;
   logic [15:0] div_r;
   logic        tick;
   logic        cmdWrite;
   logic [2:0]  inSync_r;
   logic        inFilt_r;
   logic        csN_r;
   logic        sclk_r;
   logic [5:0]  nBits;

   // Zero-wait slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Address phase capture; read data prepared for the data phase
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wrPend_r <= 1'b0;
         wrAddr_r <= 8'h00;
         hrdata   <= 32'h0;
      end else if (hready) begin
         wrPend_r <= hsel & htrans[1] & hwrite;
         wrAddr_r <= haddr[7:0];
         case (haddr[7:0])
            `REG_TXDATA: hrdata <= {8'h00, txData_r};
            `REG_RXDATA: hrdata <= {8'h00, rxData_r};
            `REG_STATUS: hrdata <= {31'h0, state_r != H_IDLE};
            `REG_WPCTRL: hrdata <= {31'h0, wpLevel_r};
            default:     hrdata <= 32'h0;
         endcase
      end
   end

   // Command write starts a frame only when idle
   assign cmdWrite = wrPend_r & (wrAddr_r == `REG_CMD) &
                     (state_r == H_IDLE);
   // Bits = 8 per byte, minus one when a short frame is asked for
   assign nBits = {1'b0, hwdata[`CMD_LEN_LSB +: 2], 3'h0} + 6'h08 -
                  {5'h00, hwdata[`CMD_TRUNC_BIT]}; // see R9

   // Data register and protect pin level
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         txData_r  <= 24'h000000;
         wpLevel_r <= 1'b1;
      end else if (wrPend_r) begin
         if (wrAddr_r == `REG_TXDATA)
            txData_r <= hwdata[23:0];
         if (wrAddr_r == `REG_WPCTRL)
            wpLevel_r <= hwdata[0]; // see R14 R16
      end
   end

   // Returned data, three-stage sampled like any pin
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         inSync_r <= 3'h0;
         inFilt_r <= 1'b0;
      end else begin
         inSync_r <= {inSync_r[1:0], link.serialOut};
         if (inSync_r[1] == inSync_r[2])
            inFilt_r <= inSync_r[2];
      end
   end

   // Half-period divider for the serial clock
   assign tick = (div_r == 16'(HALF_DIV - 1));
   always_ff @(posedge sys_clk) begin
      if (rst || state_r == H_IDLE || tick)
         div_r <= 16'h0000;
      else
         div_r <= div_r + 16'h0001;
   end

   // Frame sequencer: select low, opcode and data MSB first, release
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_r  <= H_IDLE;
         csN_r    <= 1'b1;
         sclk_r   <= 1'b0;
         shift_r  <= 32'h0;
         total_r  <= 6'h00;
         done_r   <= 6'h00;
         rxData_r <= 24'h000000;
      end else begin
         case (state_r)
            H_IDLE: begin
               if (cmdWrite) begin
                  csN_r   <= 1'b0; // see R8
                  shift_r <= {hwdata[7:0], txData_r};
                  total_r <= nBits;
                  done_r  <= 6'h00;
                  state_r <= H_SETUP;
               end
            end
            H_SETUP, H_LOW: begin
               if (tick) begin
                  sclk_r   <= 1'b1;
                  rxData_r <= {rxData_r[22:0], inFilt_r};
                  done_r   <= done_r + 6'h01;
                  state_r  <= H_HIGH;
               end
            end
            H_HIGH: begin
               if (tick) begin
                  sclk_r  <= 1'b0;
                  shift_r <= {shift_r[30:0], 1'b0};
                  state_r <= (done_r == total_r) ? H_HOLD : H_LOW;
               end
            end
            H_HOLD: begin
               if (tick) begin
                  csN_r   <= 1'b1; // see R8 R10
                  state_r <= H_GAP;
               end
            end
            H_GAP: begin
               if (tick)
                  state_r <= H_IDLE;
            end
            default: state_r <= H_IDLE;
         endcase
      end
   end

   assign link.chipSelectN     = csN_r;
   assign link.serialClk       = sclk_r;
   assign link.serialIn        = shift_r[31];
   assign link.writeProtectPin = wpLevel_r;
endmodule // flash_wp_host
`default_nettype wire

// File: flash_status_write_protection_asserts.sv
// Checker for the status-write link and the protection state
`default_nettype none
module flash_status_write_protection_asserts #(
   parameter int unsigned STATUS_WRITE_CYCLES = 20
) (
   // Clock and resets
   input wire logic                  sys_clk,
   input wire logic                  rst,
   input wire logic                  powerOnRst,
   // Serial link
   input wire logic                  chipSelectN,
   input wire logic                  serialClk,
   input wire logic                  writeProtectPin,
   // Device state
   input wire flash_wp_pkg::status_t statusOut,
   input wire logic [7:0]            configOut,
   input wire logic                  hardProtect,
   input wire logic [3:0]            dummyClocks,
   // Array requests
   input wire logic                  arrayOpReq,
   input wire logic [3:0]            arrayOpBlock,
   input wire logic                  arrayOpGranted,
   input wire logic                  arrayOpRefused
);
   timeunit 1ns;
   timeprecision 1ps;
   import flash_wp_pkg::*;
   logic [15:0] busyCnt_r;

   // Busy run length, judged at the falling edge of busy
   always_ff @(posedge sys_clk) begin
      if (rst || powerOnRst) begin
         busyCnt_r <= '0;
      end else if (statusOut.busy) begin
         busyCnt_r <= busyCnt_r + 16'h1;
      end else begin
         busyCnt_r <= '0;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst || powerOnRst);

   // Wait-state count follows the dummy select bit
   a_dummy_count: assert property (dummyClocks == (configOut[7] ? 4'h8 : 4'h6))
      else $error("dummy clock count wrong");
   a_config_reserved: assert property ((configOut & 8'h77) == 8'h00)
      else $error("reserved config bits set");
   a_bottom_sticky: assert property (configOut[3] |=> configOut[3])
      else $error("bottom protect bit returned to zero");
   a_busy_length: assert property ($fell(statusOut.busy) |-> busyCnt_r == STATUS_WRITE_CYCLES)
      else $error("timed write length wrong");
   a_end_clears: assert property ($fell(statusOut.busy) |-> !statusOut.latch)
      else $error("latch left set after write cycle");
   // Stored bits change only as a timed write begins
   a_nv_on_start: assert property (!$stable({statusOut[7:2], configOut}) |-> $rose(statusOut.busy))
      else $error("stored bits changed outside a status write");
   a_hard_frozen: assert property (hardProtect && !statusOut.busy |=> $stable(statusOut[7:2]))
      else $error("locked bits changed in hard protect mode");
   a_hard_entry: assert property ((statusOut.lockBit && !statusOut.quadEn && !writeProtectPin)[*5] |-> hardProtect)
      else $error("hard protect mode not entered");
   a_hard_cause: assert property (hardProtect |-> statusOut.lockBit && !statusOut.quadEn)
      else $error("hard protect without lock or with quad");
   a_hard_exit: assert property (writeProtectPin[*5] |-> !hardProtect)
      else $error("hard protect held with pin high");
   a_array_answer: assert property (arrayOpReq && !statusOut.busy |=> (arrayOpGranted != arrayOpRefused) && !statusOut.latch)
      else $error("array request answer wrong");
   // Designer's area map: top L blocks, or bottom L blocks
   a_array_protect: assert property (arrayOpReq && !statusOut.busy && statusOut.level != 4'h0 && (configOut[3] ? arrayOpBlock < statusOut.level : {1'b0, arrayOpBlock} >= 5'h10 - {1'b0, statusOut.level}) |=> arrayOpRefused)
      else $error("protected block not refused");
   a_idle_clock: assert property (chipSelectN |-> !serialClk)
      else $error("serial clock moved while deselected");
endmodule // flash_status_write_protection_asserts
`default_nettype wire

// File: flash_status_write_protection_test.sv
// Self-checking bench joining host and device over the link
`include "flash_wp_consts.svh"
`default_nettype none
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module flash_status_write_protection_test;
   timeunit 1ns;
   timeprecision 1ps;
   import flash_wp_pkg::*;
   localparam int unsigned SWC = 400; // Long enough to poll during busy
   logic        sys_clk = 1'b0, rst = 1'b1, powerOnRst = 1'b1;
   logic        hsel = 1'b0, hwrite = 1'b0, rdPh = 1'b0, arrayOpReq = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rdVal, expV, expM;
   logic [1:0]  htrans = 2'b00, expA;
   logic [2:0]  hsize = 3'h2;
   logic        hreadyout, hresp, arrayOpGranted, arrayOpRefused, hardProtect;
   logic [3:0]  arrayOpBlock = 4'h0, dummyClocks, lvl;
   logic [7:0]  configOut;
   status_t     statusOut;
   logic [31:0] eQ[$], mQ[$];
   logic [1:0]  aQ[$];
   int          mismatches = 0, nCompared = 0;

   flash_wp_link_if link();
   always #5 sys_clk = ~sys_clk;

   flash_wp_host #(.HALF_DIV(`HOST_HALF_DIV)) flash_wp_host_inst (
      .sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
      .link(link.host));
   flash_wp_device #(.STATUS_WRITE_CYCLES(SWC)) flash_wp_device_inst (
      .sys_clk, .rst, .powerOnRst, .link(link.device), .arrayOpReq,
      .arrayOpBlock, .arrayOpGranted, .arrayOpRefused, .statusOut,
      .configOut, .hardProtect, .dummyClocks);
   flash_status_write_protection_asserts #(.STATUS_WRITE_CYCLES(SWC))
      flash_status_write_protection_asserts_inst (
      .sys_clk, .rst, .powerOnRst, .chipSelectN(link.chipSelectN),
      .serialClk(link.serialClk), .writeProtectPin(link.writeProtectPin),
      .statusOut, .configOut, .hardProtect, .dummyClocks, .arrayOpReq,
      .arrayOpBlock, .arrayOpGranted, .arrayOpRefused);

   // Results are matched against the oldest pending note
   always @(posedge sys_clk) begin
      if (rdPh) begin
         expV = eQ.pop_front();
         expM = mQ.pop_front();
         `CHK(hrdata & expM, expV)
      end
      if (arrayOpGranted || arrayOpRefused) begin
         expA = aQ.pop_front();
         `CHK({arrayOpGranted, arrayOpRefused}, expA)
      end
   end

   // One AHB single transfer; c notes an expected read value
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d, input logic c = 1'b0,
                      input logic [31:0] e = '0, input logic [31:0] m = '0);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      if (c) begin
         eQ.push_back(e);
         mQ.push_back(m);
      end
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      rdPh <= c;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rdVal = hrdata;
      rdPh <= 1'b0;
   endtask

   // Send one frame and wait for the host to go idle
   task automatic frame(input logic [12:0] cmd, input logic [23:0] tx = '0);
      bus(`REG_TXDATA, 1'b1, {8'h0, tx});
      bus(`REG_CMD, 1'b1, {19'h0, cmd});
      rdVal = 32'h1;
      while (rdVal[0]) bus(`REG_STATUS, 1'b0, '0);
      repeat (6) @(posedge sys_clk); // Device decode trails the pin
   endtask

   // Read status or config over the link and note the expectation
   task automatic rdreg(input logic [7:0] op, input logic [7:0] e,
                        input logic [7:0] m = 8'hff);
      frame({5'h1, op});
      bus(`REG_RXDATA, 1'b0, '0, 1'b1, {24'h0, e}, {24'h0, m});
   endtask

   // Poll status until the timed write has finished
   task automatic wait_idle;
      rdVal = 32'h1;
      while (rdVal[0]) begin
         frame({5'h1, `CMD_READ_STATUS});
         bus(`REG_RXDATA, 1'b0, '0);
      end
   endtask

   // Write status then config; optional missing enable or short frame
   task automatic write_status_cmd(input logic [15:0] sc, input logic noWren = 1'b0,
                       input logic cut = 1'b0);
      if (!noWren) frame({5'h0, `CMD_WRITE_ENABLE});
      frame({cut, 4'h2, `CMD_WRITE_STATUS}, {sc, 8'h00});
   endtask

   // Pulse one array request and note the expected answer
   task automatic arr(input logic [3:0] b, input logic [1:0] e);
      aQ.push_back(e);
      @(posedge sys_clk);
      arrayOpReq <= 1'b1;
      arrayOpBlock <= b;
      @(posedge sys_clk);
      arrayOpReq <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic set_pin(input logic v);
      bus(`REG_WPCTRL, 1'b1, {31'h0, v});
      repeat (6) @(posedge sys_clk);
   endtask

   task automatic give_verdict;
      $display("Compared %0d, mismatches %0d", nCompared, mismatches);
      if (mismatches == 0 && nCompared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Watchdog cuts a hang short
   initial begin
      repeat (95000) @(posedge sys_clk);
      mismatches++;
      give_verdict;
   end

   // Main sequence
   initial begin
      void'($urandom(47));
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      powerOnRst <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rdreg(`CMD_READ_STATUS, 8'h00);
      rdreg(`CMD_READ_CONFIG, 8'h00);
      write_status_cmd(16'hbc88, 1'b1);
      rdreg(`CMD_READ_STATUS, 8'h00);
      frame({5'h0, `CMD_WRITE_ENABLE});
      rdreg(`CMD_READ_STATUS, 8'h02);
      frame({5'h0, `CMD_WRITE_DISABLE});
      rdreg(`CMD_READ_STATUS, 8'h00);
      write_status_cmd(16'h3c00, 1'b0, 1'b1);
      rdreg(`CMD_READ_STATUS, 8'h00, 8'hfc);
      // Busy and latch written as ones must not stick
      lvl = 4'($urandom_range(15, 1));
      write_status_cmd({2'b00, lvl, 2'b11, 8'h80});
      rdreg(`CMD_READ_STATUS, {2'b00, lvl, 2'b11});
      wait_idle;
      rdreg(`CMD_READ_STATUS, {2'b00, lvl, 2'b00});
      rdreg(`CMD_READ_CONFIG, 8'h80);
      // Array requests against the top area
      arr(4'h0, 2'b01);
      frame({5'h0, `CMD_WRITE_ENABLE});
      arr(4'hf, 2'b01);
      rdreg(`CMD_READ_STATUS, {2'b00, lvl, 2'b00});
      frame({5'h0, `CMD_WRITE_ENABLE});
      arr(4'h0, 2'b10);
      // Device reset alone keeps the stored bits
      @(posedge sys_clk) rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (6) @(posedge sys_clk);
      rdreg(`CMD_READ_STATUS, {2'b00, lvl, 2'b00});
      rdreg(`CMD_READ_CONFIG, 8'h00);
      // Bottom area bit can be set but never cleared
      write_status_cmd(16'h0008);
      wait_idle;
      rdreg(`CMD_READ_CONFIG, 8'h08);
      write_status_cmd(16'h0000);
      wait_idle;
      rdreg(`CMD_READ_CONFIG, 8'h08);
      // Lock bit with the pin low freezes the status
      write_status_cmd(16'h8000);
      wait_idle;
      set_pin(1'b0);
      write_status_cmd(16'h3c00);
      wait_idle;
      rdreg(`CMD_READ_STATUS, 8'h80, 8'hfc);
      set_pin(1'b1);
      write_status_cmd(16'h0000);
      wait_idle;
      rdreg(`CMD_READ_STATUS, 8'h00);
      // Quad mode and a clear lock both leave writes open
      write_status_cmd(16'hc000);
      wait_idle;
      set_pin(1'b0);
      write_status_cmd(16'h4000);
      wait_idle;
      rdreg(`CMD_READ_STATUS, 8'h40);
      write_status_cmd(16'h0400);
      wait_idle;
      rdreg(`CMD_READ_STATUS, 8'h04);
      // Status-only write leaves the config byte alone
      frame({5'h0, `CMD_WRITE_ENABLE});
      frame({5'h1, `CMD_WRITE_STATUS}, 24'h080000);
      wait_idle;
      rdreg(`CMD_READ_STATUS, 8'h08);
      rdreg(`CMD_READ_CONFIG, 8'h08);
      set_pin(1'b1);
      // Every noted answer must have turned up
      `CHK(aQ.size(), 0)
      `CHK(eQ.size(), 0)
      give_verdict;
   end
endmodule // flash_status_write_protection_test
`default_nettype wire
